// file: hdl/sai_top.sv
/*
 * Serial audio input port: bit-clock receiver, clock supervisor,
 * register port and sample fifo.
 * Assumes the word clock and data change on the falling bit clock
 * edge, and that the register port is driven in the CLK domain.
 */
// Operation
// [RULE_01] data bits are shifted in on the rising bit clock edge
// [RULE_02] two-channel formats take 16 to 32 bit words, ratio 32 or 64
// [RULE_03] tdm ratio 128 at 32k, up to 512 at 48k, 256 at 96k
// [RULE_04] frame period is measured and the rate class chosen automatically
// [RULE_05] measured ratio steers the internal pll, no master clock needed
// [RULE_06] halt or bad ratio raises clock error in status register 0x71
// [RULE_07] halt puts channels in hi-z, recovery restores previous state
// [RULE_08] host keeps clocks halted 10 ms before a new rate
// [RULE_09] format bits 5:4 select i2s, left, right justified or tdm
// [RULE_10] host sets bits 3:2 to 01 for short tdm frame sync
// [RULE_11] samples are two's complement msb first, up to 32 bits
// [RULE_12] bits 1:0 give word length, reset is i2s 24 bit
// [RULE_13] tdm offset is format bits 7:6 with offset register bits
// [RULE_14] tdm frame of 16 slots at 48k, 8 at 96k, offset picks slot
// [RULE_15] tdm frame starts at frame sync rising edge
// [RULE_16] i2s word clock low is left, high is right
// [RULE_17] host starts clocks before initialising registers
// [RULE_18] samples go to a fixed processing flow at 96k
// [RULE_19] halt on idle timeout, cleared after stable frames
`timescale 1ns/1ns
`include "sai_params.svh"

// ==========================================================
// sample fifo
module sai_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   // clock and reset
   input logic clk,
   input logic rst_n,
   // fill side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, rd_ff;
   logic [AW:0] cnt_ff;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW-1:0] nxt_wr = (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
   wire [AW-1:0] nxt_rd = (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
   // honest full and empty from the count
   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   // storage
   always_ff @(posedge clk) begin
      if (push) mem_ff[wr_ff] <= in_data;
   end
   // pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= nxt_wr;
         if (pop) rd_ff <= nxt_rd;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==========================================================
// top
module sai_top #(
   parameter int FIFO_DEPTH = 8,
   parameter int HALT_CYC = `SAI_HALT_CYC
) (
   // system clock and reset
   input logic CLK,
   input logic RST_N,
   // serial audio link
   input logic BIT_CLK,
   input logic WORD_CLOCK_FRAME_SYNC,
   input logic SERIAL_AUDIO_IN,
   // register port
   input logic [7:0] REG_ADDR,
   input logic REG_WR,
   input logic REG_RD,
   input logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // operating state and outputs
   input logic PLAY_REQ,
   output logic [1:0] CH_HIZ,
   output sai_pkg::sai_rate_t RATE_SEL,
   output logic PLL_EN,
   output logic [9:0] PLL_FB_DIV,
   // samples toward the processing flow
   output logic SAMPLE_VALID,
   input logic SAMPLE_READY,
   output sai_pkg::sai_sample_t SAMPLE
);
   import sai_pkg::*;

   // ==========================================================
   // reset synchronisers, one per domain
   logic rst_m_ff, rst_n_ff, brst_m_ff, brst_n_ff;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) {rst_n_ff, rst_m_ff} <= 2'b00;
      else {rst_n_ff, rst_m_ff} <= {rst_m_ff, 1'b1};
   end
   always_ff @(posedge BIT_CLK or negedge RST_N) begin
      if (!RST_N) {brst_n_ff, brst_m_ff} <= 2'b00;
      else {brst_n_ff, brst_m_ff} <= {brst_m_ff, 1'b1};
   end

   // ==========================================================
   // registers, CLK domain
   logic [7:0] fmt_ff, ofs_ff;
   logic ovr_ff;
   sai_state_t st_ff;
   sai_rate_t rate_ff;
   logic ratio_err_ff;
   wire wr_fmt = REG_WR & (REG_ADDR == `SAI_ADDR_FMT);
   wire wr_ofs = REG_WR & (REG_ADDR == `SAI_ADDR_OFS);
   wire rd_stat = REG_RD & (REG_ADDR == `SAI_ADDR_STAT);
   wire [7:0] stat_val;
   // status register contents
   assign stat_val[`SAI_ST_ERR] = (st_ff != ST_RUN); // RULE_06
   assign stat_val[`SAI_ST_HALT] = (st_ff == ST_HALT);
   assign stat_val[`SAI_ST_RATIO] = ratio_err_ff;
   assign stat_val[`SAI_ST_OVR] = ovr_ff;
   assign stat_val[`SAI_ST_RATE_LSB+:2] = rate_ff;
   assign stat_val[7:6] = 2'b00;
   // read selection, unmapped reads zero
   wire [7:0] rd_val =
      (REG_ADDR == `SAI_ADDR_FMT) ? fmt_ff :
      (REG_ADDR == `SAI_ADDR_OFS) ? ofs_ff :
      (REG_ADDR == `SAI_ADDR_STAT) ? stat_val : 8'h00;
   // writes and registered read data
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         fmt_ff <= `SAI_FMT_RST; // RULE_12
         ofs_ff <= `SAI_OFS_RST;
         REG_RDATA <= 8'h00;
      end else begin
         if (wr_fmt) fmt_ff <= REG_WDATA;
         if (wr_ofs) ofs_ff <= REG_WDATA;
         if (REG_RD) REG_RDATA <= rd_val;
      end
   end

   // ==========================================================
   // link domain: configuration crossing, static while running
   logic [15:0] cfg_m_ff, cfg_s_ff;
   always_ff @(posedge BIT_CLK or negedge brst_n_ff) begin
      if (!brst_n_ff) begin
         cfg_m_ff <= {`SAI_OFS_RST, `SAI_FMT_RST};
         cfg_s_ff <= {`SAI_OFS_RST, `SAI_FMT_RST};
      end else begin
         cfg_m_ff <= {ofs_ff, fmt_ff};
         cfg_s_ff <= cfg_m_ff;
      end
   end
   wire [1:0] wl_code = cfg_s_ff[`SAI_FMT_WL_LSB+:2];
   wire sai_fmt_t mode = sai_fmt_t'(cfg_s_ff[`SAI_FMT_MODE_LSB+:2]); // RULE_09
   wire tdm = (mode == FMT_TDM);
   wire [10:0] off = {1'b0, cfg_s_ff[`SAI_FMT_OFSH_LSB+:2], cfg_s_ff[15:8]}; // RULE_13
   // word length in bits
   wire [5:0] wl_bits = (wl_code == 2'd0) ? 6'd16 :
                        (wl_code == 2'd1) ? 6'd20 :
                        (wl_code == 2'd2) ? 6'd24 : 6'd32; // RULE_12

   // ==========================================================
   // link domain: pin capture and bit position
   logic lr_ff, lr_prev_ff, din_ff;
   logic [9:0] cnt_ff, half_ff, fcnt_ff, ratio_ff;
   logic fr_tgl_ff;
   wire lr_edge = lr_ff ^ lr_prev_ff;
   wire lr_rise = lr_ff & ~lr_prev_ff; // RULE_15
   wire restart = tdm ? lr_rise : lr_edge;
   wire [9:0] pos = restart ? 10'd0 : cnt_ff;
   wire [9:0] nxt_cnt = (cnt_ff == 10'h3FF) ? cnt_ff : cnt_ff + 10'd1;
   wire [9:0] nxt_fcnt = (fcnt_ff == 10'h3FF) ? fcnt_ff : fcnt_ff + 10'd1;
   // sample pins on the rising bit clock
   always_ff @(posedge BIT_CLK or negedge brst_n_ff) begin
      if (!brst_n_ff) begin
         lr_ff <= 1'b0;
         lr_prev_ff <= 1'b0;
         din_ff <= 1'b0;
      end else begin
         lr_ff <= WORD_CLOCK_FRAME_SYNC;
         lr_prev_ff <= lr_ff;
         din_ff <= SERIAL_AUDIO_IN; // RULE_01
      end
   end
   // half and frame length counters
   always_ff @(posedge BIT_CLK or negedge brst_n_ff) begin
      if (!brst_n_ff) begin
         cnt_ff <= 10'd0;
         half_ff <= 10'd0;
         fcnt_ff <= 10'd0;
         ratio_ff <= 10'd0;
         fr_tgl_ff <= 1'b0;
      end else begin
         cnt_ff <= restart ? 10'd1 : nxt_cnt;
         if (restart) half_ff <= cnt_ff;
         fcnt_ff <= lr_rise ? 10'd1 : nxt_fcnt;
         if (lr_rise) begin
            ratio_ff <= fcnt_ff;
            fr_tgl_ff <= ~fr_tgl_ff;
         end
      end
   end

   // ==========================================================
   // link domain: word window and shift register
   wire [10:0] pos11 = {1'b0, pos};
   wire [10:0] wl11 = {5'd0, wl_bits};
   wire [10:0] slot = 11'(`SAI_SLOT_BITS);
   wire tdm_right = pos11 >= (off + slot); // RULE_14
   // first data bit after the word clock edge
   wire [10:0] st2ch = (mode == FMT_I2S) ? 11'd1 :
                       (mode == FMT_LEFT_JUSTIFIED) ? 11'd0 :
                       ({1'b0, half_ff} - wl11);
   wire [10:0] st = tdm ? (tdm_right ? off + slot : off) : st2ch;
   wire [10:0] st_end = st + wl11;
   wire in_word = (pos11 >= st) && (pos11 < st_end);
   wire last_bit = (pos11 == st_end - 11'd1);
   // i2s low is left, justified formats high is left
   wire is_right = tdm ? tdm_right :
                   (mode == FMT_I2S) ? lr_ff : ~lr_ff; // RULE_16
   logic [31:0] sh_ff, left_ff;
   sai_sample_t smp_ff;
   logic smp_tgl_ff;
   wire [31:0] sh_nxt = {sh_ff[30:0], din_ff}; // RULE_11
   wire [31:0] word = sh_nxt << (6'd32 - wl_bits); // RULE_02
   // msb first shift and word hand-off
   always_ff @(posedge BIT_CLK or negedge brst_n_ff) begin
      if (!brst_n_ff) begin
         sh_ff <= 32'h0000_0000;
         left_ff <= 32'h0000_0000;
         smp_ff <= '0;
         smp_tgl_ff <= 1'b0;
      end else begin
         if (in_word) sh_ff <= sh_nxt;
         if (in_word && last_bit && !is_right) left_ff <= word;
         if (in_word && last_bit && is_right) begin
            smp_ff <= '{left: left_ff, right: word};
            smp_tgl_ff <= ~smp_tgl_ff;
         end
      end
   end

   // ==========================================================
   // CLK domain: event crossings by toggle
   logic [2:0] fr_sync_ff, smp_sync_ff;
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         fr_sync_ff <= 3'b000;
         smp_sync_ff <= 3'b000;
      end else begin
         fr_sync_ff <= {fr_sync_ff[1:0], fr_tgl_ff};
         smp_sync_ff <= {smp_sync_ff[1:0], smp_tgl_ff};
      end
   end
   wire fr_evt = fr_sync_ff[2] ^ fr_sync_ff[1];
   wire smp_evt = smp_sync_ff[2] ^ smp_sync_ff[1];

   // ==========================================================
   // CLK domain: rate detection and ratio check
   logic [11:0] per_ff;
   logic [2:0] good_ff;
   logic [9:0] fb_ff;
   wire idle = (per_ff >= 12'(HALT_CYC)); // RULE_19
   wire sai_rate_t rate_now =
      (per_ff >= 12'(`SAI_PER_32K_MIN) && per_ff < 12'(`SAI_PER_32K_MAX)) ? RATE_32K :
      (per_ff >= 12'(`SAI_PER_48K_MIN) && per_ff < 12'(`SAI_PER_32K_MIN)) ? RATE_48K :
      (per_ff >= 12'(`SAI_PER_96K_MIN) && per_ff < 12'(`SAI_PER_48K_MIN)) ? RATE_96K :
      RATE_NONE; // RULE_04
   wire ok_tdm = (ratio_ff == 10'd128) ||
                 ((ratio_ff == 10'd256) && (rate_now != RATE_32K)) ||
                 ((ratio_ff == 10'd512) && (rate_now == RATE_48K)); // RULE_03
   wire ok_2ch = (ratio_ff == 10'd32) || (ratio_ff == 10'd64); // RULE_02
   // framing taken from the CLK side copy, the link copy stalls with the bit clock
   wire tdm_sys = (sai_fmt_t'(fmt_ff[`SAI_FMT_MODE_LSB+:2]) == FMT_TDM); // RULE_09
   wire frame_ok = (rate_now != RATE_NONE) && (tdm_sys ? ok_tdm : ok_2ch);
   wire same_rate = (rate_now == rate_ff);
   wire stable = frame_ok && same_rate && (good_ff == 3'(`SAI_STABLE_FRAMES - 1));
   wire [11:0] nxt_per = idle ? per_ff : per_ff + 12'd1;
   // period counter and per-frame checks
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         per_ff <= 12'd0;
         good_ff <= 3'd0;
         rate_ff <= RATE_NONE;
         ratio_err_ff <= 1'b0;
         fb_ff <= 10'd0;
      end else if (fr_evt) begin
         per_ff <= 12'd1;
         rate_ff <= rate_now;
         ratio_err_ff <= ~frame_ok; // RULE_06
         good_ff <= (frame_ok && same_rate && !stable) ? good_ff + 3'd1 : 3'd0;
         if (frame_ok) fb_ff <= ratio_ff; // RULE_05
      end else begin
         per_ff <= nxt_per;
         if (idle) good_ff <= 3'd0;
      end
   end

   // ==========================================================
   // CLK domain: clock supervisor
   logic [1:0] hiz_ff;
   sai_state_t nxt_st;
   // halt, lock and run transitions
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_HALT: begin
            if (fr_evt) nxt_st = ST_LOCK;
         end
         ST_LOCK: begin
            if (idle) nxt_st = ST_HALT;
            else if (fr_evt && stable) nxt_st = ST_RUN; // RULE_19
         end
         ST_RUN: begin
            if (idle) nxt_st = ST_HALT; // RULE_07
            else if (fr_evt && !frame_ok) nxt_st = ST_LOCK;
         end
         default: nxt_st = ST_HALT;
      endcase
   end
   // state and output stage, play request is kept across a halt
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         st_ff <= ST_HALT;
         hiz_ff <= 2'b11;
      end else begin
         st_ff <= nxt_st;
         hiz_ff <= {2{(nxt_st != ST_RUN) || !PLAY_REQ}}; // RULE_07
      end
   end
   assign CH_HIZ = hiz_ff;
   assign RATE_SEL = rate_ff;
   assign PLL_EN = (st_ff != ST_HALT); // RULE_05
   assign PLL_FB_DIV = fb_ff;

   // ==========================================================
   // CLK domain: samples into the fifo, overrun is sticky
   wire fifo_in_ready;
   wire push_req = smp_evt && (st_ff == ST_RUN); // RULE_18
   wire overrun = push_req && !fifo_in_ready;
   // set wins over clear on read
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) ovr_ff <= 1'b0;
      else if (overrun) ovr_ff <= 1'b1;
      else if (rd_stat) ovr_ff <= 1'b0;
   end
   wire [63:0] fifo_out;
   sai_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst_n(rst_n_ff),
      .in_valid(push_req),
      .in_ready(fifo_in_ready),
      .in_data(smp_ff),
      .out_valid(SAMPLE_VALID),
      .out_ready(SAMPLE_READY),
      .out_data(fifo_out)
   );
   assign SAMPLE = sai_sample_t'(fifo_out);
endmodule

// file: include/sai_params.svh
/*
 * Constants of the serial audio input port: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a bit clock of at most ~25 MHz.
 */
`ifndef SAI_PARAMS_SVH
`define SAI_PARAMS_SVH
// ==========================================================
// register offsets
`define SAI_ADDR_FMT 8'h33
`define SAI_ADDR_OFS 8'h34
`define SAI_ADDR_STAT 8'h71
// ==========================================================
// reset values: i2s framing, 24-bit words, zero offset
`define SAI_FMT_RST 8'h02
`define SAI_OFS_RST 8'h00
// ==========================================================
// field positions of the format register
`define SAI_FMT_WL_LSB 0
`define SAI_FMT_FSW_LSB 2
`define SAI_FMT_MODE_LSB 4
`define SAI_FMT_OFSH_LSB 6
// ==========================================================
// field positions of the status register
`define SAI_ST_ERR 0
`define SAI_ST_HALT 1
`define SAI_ST_RATIO 2
`define SAI_ST_OVR 3
`define SAI_ST_RATE_LSB 4
// ==========================================================
// timing
`define SAI_CLK_HZ 10_000_000
`define SAI_HALT_US 200
`define SAI_HALT_CYC (`SAI_HALT_US * (`SAI_CLK_HZ / 1_000_000))
`define SAI_STABLE_FRAMES 4
// frame period windows in system clocks
`define SAI_PER_32K_MIN 260
`define SAI_PER_32K_MAX 400
`define SAI_PER_48K_MIN 160
`define SAI_PER_96K_MIN 80
// tdm slot width in bit clocks
`define SAI_SLOT_BITS 32
`endif

// file: include/sai_pkg.sv
/*
 * Types of the serial audio input port.
 * Assumes sai_params.svh supplies all numeric constants.
 */
package sai_pkg;
   // framing selected by format bits 5:4
   typedef enum logic [1:0] {
      FMT_I2S = 2'b00,
      FMT_LEFT_JUSTIFIED = 2'b01,
      FMT_RIGHT_JUSTIFIED = 2'b10,
      FMT_TDM = 2'b11
   } sai_fmt_t;
   // detected sample rate class
   typedef enum logic [1:0] {
      RATE_32K = 2'b00,
      RATE_48K = 2'b01,
      RATE_96K = 2'b10,
      RATE_NONE = 2'b11
   } sai_rate_t;
   // clock supervisor, gray along halt, lock, run
   typedef enum logic [1:0] {
      ST_HALT = 2'b00,
      ST_LOCK = 2'b01,
      ST_RUN = 2'b11
   } sai_state_t;
   // one stereo sample, left aligned, two's complement
   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } sai_sample_t;
endpackage

// file: verif/sai_top_sva.sv
/*
 checker of the serial audio input port, top ports only.
 assumes a bind into sai_top and the clk domain alone watched.
*/
`timescale 1ns/1ns
`include "sai_params.svh"
module sai_top_sva
   import sai_pkg::*;
(
   // clock and reset
   input logic CLK,
   input logic RST_N,
   // register port
   input logic [7:0] REG_ADDR,
   input logic REG_WR,
   input logic REG_RD,
   input logic [7:0] REG_WDATA,
   input logic [7:0] REG_RDATA,
   // state and samples
   input logic PLAY_REQ,
   input logic [1:0] CH_HIZ,
   input sai_pkg::sai_rate_t RATE_SEL,
   input logic PLL_EN,
   input logic SAMPLE_VALID,
   input logic SAMPLE_READY,
   input sai_pkg::sai_sample_t SAMPLE
);
   import sai_pkg::*;
   logic [1:0] wl_ff;
   logic [1:0] nxt_wl;
   logic [31:0] low_mask;
   logic mapped;
   // ==========================================================
   // word length shadow, bits below the word must be zero
   assign nxt_wl = (REG_WR && REG_ADDR == `SAI_ADDR_FMT) ? REG_WDATA[1:0] : wl_ff;
   assign low_mask = (wl_ff == 2'b00) ? 32'h0000_ffff : (wl_ff == 2'b01) ? 32'h0000_0fff :
                     (wl_ff == 2'b10) ? 32'h0000_00ff : 32'h0000_0000;
   assign mapped = REG_ADDR inside {`SAI_ADDR_FMT, `SAI_ADDR_OFS, `SAI_ADDR_STAT};
   // shadow register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wl_ff <= 2'b10;
      end else begin
         wl_ff <= nxt_wl;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_lock_start;
      $rose(PLL_EN);
   endsequence
   sequence s_status_read;
      REG_RD && REG_ADDR == `SAI_ADDR_STAT;
   endsequence
   a_hiz_pair: assert property (CH_HIZ[0] == CH_HIZ[1])
      else $error("channel hi-z bits differ");
   a_halt_hiz: assert property (!PLL_EN |-> CH_HIZ == 2'b11)
      else $error("channels driven while halted");
   a_play_follow: assert property (CH_HIZ == 2'b00 |-> PLL_EN && $past(PLAY_REQ))
      else $error("channels driven without play request");
   a_lock_wait: assert property (s_lock_start |-> (CH_HIZ == 2'b11) [*8])
      else $error("run entered before stable frames");
   a_status_bits: assert property (s_status_read |=> REG_RDATA[7:6] == 2'b00 &&
      REG_RDATA[5:4] == $past(RATE_SEL) && REG_RDATA[1] == !$past(PLL_EN))
      else $error("status read disagrees with state");
   a_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without read");
   a_sample_hold: assert property (SAMPLE_VALID && !SAMPLE_READY |=> SAMPLE_VALID && $stable(SAMPLE))
      else $error("sample lost while stalled");
   a_drain_only: assert property ($fell(SAMPLE_VALID) |-> $past(SAMPLE_READY))
      else $error("sample valid fell without drain");
   a_low_zero: assert property (SAMPLE_VALID |-> ((SAMPLE.left & low_mask) == 32'h0000_0000) &&
      ((SAMPLE.right & low_mask) == 32'h0000_0000))
      else $error("bits below word length not zero");
endmodule

// file: verif/sai_host_model.sv
/*
 host model: sends tdm frames of 32 bit slots on a 64 ns bit clock.
 assumes the bench raises run only to send frames.
*/
`timescale 1ns/1ns
module sai_host_model (
   // control from the bench
   input logic run,
   input logic [9:0] ratio,
   input logic [127:0] words,
   // serial link
   output logic bclk,
   output logic fs,
   output logic serial_audio_in
);
   int p;
   int s;
   // idle link at time zero
   initial begin
      bclk = 0;
      fs = 0;
      serial_audio_in = 0;
      p = 0;
   end
   // bit clock stands still low between bursts
   always begin
      #32;
      if (run || bclk) begin
         bclk = ~bclk;
      end
   end
   // sync and data change on the falling edge, msb first
   always @(negedge bclk) begin
      s = (p / 32) % 4;
      fs = (p == 0);
      serial_audio_in = words[32 * s + 31 - p % 32];
      p = (p + 1) % ratio;
   end
   // released data line flips, frame restarts
   always @(negedge run) begin
      serial_audio_in = ~serial_audio_in;
      fs = 0;
      p = 0;
   end
endmodule

// file: verif/tb.sv
/*
 testbench of the serial audio input port.
 assumes sai_pkg, the design and the host model compiled first.
*/
`timescale 1ns/1ns
module tb;
   import sai_pkg::*;
   logic clk, rst_n, bclk, fs, serial_audio_in, reg_wr, reg_rd, play_req, sample_ready, pll_en, sample_valid, run;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] ch_hiz;
   logic [9:0] pll_fb_div, ratio;
   logic [127:0] words;
   sai_rate_t rate_sel;
   sai_sample_t sample;
   int mismatches, tests_run;
   // ==========================================================
   // design and host
   sai_top #(.FIFO_DEPTH(8), .HALT_CYC(400)) u_sai_top (.CLK(clk), .RST_N(rst_n), .BIT_CLK(bclk),
      .WORD_CLOCK_FRAME_SYNC(fs), .SERIAL_AUDIO_IN(serial_audio_in), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PLAY_REQ(play_req), .CH_HIZ(ch_hiz),
      .RATE_SEL(rate_sel), .PLL_EN(pll_en), .PLL_FB_DIV(pll_fb_div), .SAMPLE_VALID(sample_valid),
      .SAMPLE_READY(sample_ready), .SAMPLE(sample));
   sai_host_model u_sai_host_model (.run(run), .ratio(ratio), .words(words), .bclk(bclk), .fs(fs), .serial_audio_in(serial_audio_in));
   // clock
   initial clk = 0;
   always #50 clk = ~clk;
   // ==========================================================
   // tasks
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task tick;
      @(posedge clk);
      #10;
   endtask
   task reg_wr_t(input logic [7:0] a, input logic [7:0] d);
      tick;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      tick;
      reg_wr = 0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      tick;
      reg_addr = a;
      reg_rd = 1;
      tick;
      reg_rd = 0;
      check("register", {56'h0, reg_rdata & m}, {56'h0, exp});
   endtask
   task wait_valid(input int n);
      int i;
      for (i = 0; i < n && sample_valid !== 1'b1; i++) begin
         tick;
      end
      check("sample_valid", {63'h0, sample_valid}, 64'h1);
   endtask
   task finish_test;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #3_000_000;
      mismatches++;
      finish_test;
   end
   // ==========================================================
   // scenarios
   initial begin
      rst_n = 0;
      reg_addr = 0;
      reg_wdata = 0;
      reg_wr = 0;
      reg_rd = 0;
      play_req = 1;
      sample_ready = 0;
      run = 0;
      ratio = 10'd128;
      words = {32'hC3B2_A190, 32'h0F1E_2D3C, 32'h8765_4321, 32'h1111_2222};
      mismatches = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      #10 rst_n = 1;
      repeat (2) tick;
      // reset values, read-only status, unmapped place
      rd_chk(8'h33, 8'h02, 8'hff);
      rd_chk(8'h34, 8'h00, 8'hff);
      rd_chk(8'h71, 8'h33, 8'hff);
      reg_wr_t(8'h71, 8'h00);
      rd_chk(8'h71, 8'h33, 8'hff);
      rd_chk(8'h50, 8'h00, 8'hff);
      // clocks first, then tdm, short sync, 32 bit, offset one slot
      run = 1;
      reg_wr_t(8'h34, 8'h20);
      reg_wr_t(8'h33, 8'h37);
      rd_chk(8'h33, 8'h37, 8'hff);
      wait_valid(2000);
      check("rate", {62'h0, rate_sel}, {62'h0, RATE_96K});
      check("pll_div", {54'h0, pll_fb_div}, 64'd128);
      check("hiz", {62'h0, ch_hiz}, 64'h0);
      // stalled drain fills the fifo until it refuses
      repeat (1100) tick;
      // drain starts before the status read so no new overrun follows the clear
      sample_ready = 1;
      rd_chk(8'h71, 8'h28, 8'hff);
      repeat (8) begin
         check("sample", sample, {words[63:32], words[95:64]});
         tick;
      end
      rd_chk(8'h71, 8'h20, 8'hff);
      // halt: hi-z and clock error
      run = 0;
      repeat (600) tick;
      check("hiz", {62'h0, ch_hiz}, 64'h3);
      check("pll_en", {63'h0, pll_en}, 64'h0);
      rd_chk(8'h71, 8'h03, 8'h03);
      // new rate after a long halt, 24 bit, offset two slots
      reg_wr_t(8'h33, 8'h36);
      reg_wr_t(8'h34, 8'h40);
      repeat (400) tick;
      ratio = 10'd256;
      run = 1;
      wait_valid(3000);
      check("sample", sample, {words[95:72], 8'h00, words[127:104], 8'h00});
      check("rate", {62'h0, rate_sel}, {62'h0, RATE_48K});
      check("pll_div", {54'h0, pll_fb_div}, 64'd256);
      check("hiz", {62'h0, ch_hiz}, 64'h0);
      play_req = 0;
      tick;
      tick;
      check("hiz", {62'h0, ch_hiz}, 64'h3);
      // ratio 512 at 32k is refused
      run = 0;
      repeat (600) tick;
      ratio = 10'd512;
      run = 1;
      repeat (3500) tick;
      rd_chk(8'h71, 8'h05, 8'h05);
      check("sample_valid", {63'h0, sample_valid}, 64'h0);
      // halted reconfiguration: 16 bit, offset half a slot, play restored
      run = 0;
      repeat (600) tick;
      reg_wr_t(8'h33, 8'h34);
      reg_wr_t(8'h34, 8'h10);
      play_req = 1;
      ratio = 10'd128;
      run = 1;
      wait_valid(2000);
      check("sample", sample, {words[15:0], 16'h0000, words[47:32], 16'h0000});
      check("hiz", {62'h0, ch_hiz}, 64'h0);
      finish_test;
   end
endmodule
bind sai_top sai_top_sva u_sai_top_sva (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PLAY_REQ(PLAY_REQ), .CH_HIZ(CH_HIZ),
   .RATE_SEL(RATE_SEL), .PLL_EN(PLL_EN), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
   .SAMPLE(SAMPLE));
